// ---- pkg/bpf_cfg.svh ----
// Block protocol framer constants
`ifndef BPF_CFG_SVH
`define BPF_CFG_SVH
`define BPF_CLK_HZ 125000000
`define BPF_CLK_NS 8
`define BPF_EXT_RST_NS 1000
`define BPF_EXT_RST_CYC ((`BPF_EXT_RST_NS + `BPF_CLK_NS - 1) / `BPF_CLK_NS)
`define BPF_CHAR_BITS 10
`define BPF_ATR_BAUD 9600
`define BPF_ATR_BYTE_CYC (`BPF_CLK_HZ / (`BPF_ATR_BAUD / `BPF_CHAR_BITS))
`define BPF_INF_MAX 8'hFE
`define BPF_HDR_BYTES 9'h003
`define BPF_CRC_INIT 16'hFFFF
`define BPF_CRC_POLY 16'h8408
`define BPF_R_TAG 3'h4
`define BPF_S_RESP 8'h20
`define BPF_S_RESYNC 8'hC0
`define BPF_S_ABORT 8'hC2
`define BPF_S_WTX 8'hC3
`define BPF_ERR_NONE 4'h0
`define BPF_ERR_CHK 4'h1
`define BPF_ERR_OTHER 4'h2
`define BPF_READER_NODE 4'h1
`define BPF_ATR_FIXED 88'h3BF37100FF918171FF0100
`define BPF_ATR_NAD 8'h11
`define BPF_ATR_LEN 9'h00F
`define BPF_REG_CTRL 8'h00
`define BPF_REG_HDR 8'h04
`define BPF_REG_TXDATA 8'h08
`define BPF_REG_STATUS 8'h0C
`define BPF_REG_GAP 8'h10
`endif

// ---- pkg/bpf_pkg.sv ----
// Block protocol framer types, shared check function and rate multiplier
`include "bpf_cfg.svh"
package bpf_pkg;
    typedef enum logic [1:0] {IF_RS485, IF_RS232, IF_CMOS, IF_BAD} bpf_iface_t;
    typedef enum logic [1:0] {ST_ATR, ST_RX, ST_TX} bpf_rd_st_t;

    // Reflected CRC-16, one byte at a time
    function automatic logic [15:0] bpf_crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `BPF_CRC_POLY) : (r >> 1);
        return r;
    endfunction : bpf_crc_upd

    // Programmed rate as a multiple of the answer-to-reset rate
    function automatic int bpf_rate_mul(input logic [2:0] s);
        case (s)
            3'h1: return 2;
            3'h2: return 4;
            3'h3: return 6;
            3'h4: return 12;
            3'h5: return 24;
            default: return 1;
        endcase
    endfunction : bpf_rate_mul
endpackage : bpf_pkg

// ---- pkg/bpf_if.sv ----
// Byte link between host controller and reader
`timescale 1ns/1ps
`default_nettype none
interface bpf_if;
    logic       h2r_vld;
    logic [7:0] h2r_dat;
    logic       r2h_vld;
    logic [7:0] r2h_dat;
    logic       ext_rst_n;
    modport reader (input h2r_vld, h2r_dat, ext_rst_n, output r2h_vld, r2h_dat);
    modport host (output h2r_vld, h2r_dat, ext_rst_n, input r2h_vld, r2h_dat);
endinterface : bpf_if
`default_nettype wire

// ---- core/bpf_reader.sv ----
// Reader end: answer-to-reset, block parser and reply framer
`timescale 1ns/1ps
`default_nettype none
module bpf_reader
    import bpf_pkg::*;
#(
    parameter logic [7:0] FW_VER_HI    = 8'h01, // Arbitrary value
    parameter logic [7:0] FW_VER_LO    = 8'h00, // Arbitrary value
    parameter int         ATR_BYTE_CYC = `BPF_ATR_BYTE_CYC
)(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Link
    bpf_if.reader           lk,
    // Configuration
    input  wire logic       par_mode_i,
    input  wire logic [2:0] rate_sel_i,
    input  wire logic       lrc_mode_i,
    input  wire logic       iface_select_sw_a_i,
    input  wire logic       iface_select_sw_b_i,
    input  wire logic       iface_select_sw_c_i,
    // Status and received data
    output bpf_iface_t      iface_mode_o,
    output logic            atr_done_o,
    output logic            inf_vld_o,
    output logic [7:0]      inf_dat_o,
    output logic            blk_end_o,
    output logic            blk_ok_o,
    output logic            mgmt_o,
    output logic [7:0]      mgmt_pcb_o
);
    function automatic logic [7:0] atr_tck();
        logic [7:0] x;
        logic [87:0] f;
        f = `BPF_ATR_FIXED;
        x = FW_VER_HI ^ FW_VER_LO ^ `BPF_ATR_NAD;
        for (int i = 0; i < 10; i++)
            x = x ^ f[8*i +: 8];
        return x;
    endfunction : atr_tck

    localparam logic [7:0]  ATR_TCK = atr_tck();
    localparam logic [87:0] ATR_FIX = `BPF_ATR_FIXED;
    localparam int          RST_CYC = `BPF_EXT_RST_CYC;

    logic [7:0]  ext_cnt_ff;
    logic        srst;
    bpf_rd_st_t  st_ff;
    logic [8:0]  idx_ff;
    logic [17:0] pace_ff;
    logic [17:0] period;
    logic [7:0]  tx_byte;
    logic        tx_go;
    logic        tx_last;
    logic [7:0]  rnad_ff;
    logic [7:0]  rpcb_ff;
    logic [7:0]  rlen_ff;
    logic [7:0]  e1_ff;
    logic [15:0] crc_ff;
    logic [7:0]  lrc_ff;
    logic        ns_ff;
    logic [7:0]  rep_nad_ff;
    logic [7:0]  rep_pcb_ff;
    logic [15:0] rep_chk_ff;
    logic        rx_b;
    logic        rx_last;
    logic [8:0]  inf_end;
    logic        chk_ok;
    logic [15:0] got;
    logic [7:0]  rp;
    logic        nxt_ns;
    logic        mgmt;
    logic [7:0]  rnad_nxt;
    logic [15:0] rchk_nxt;

    // Line held low past the minimum keeps the reader in reset
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || lk.ext_rst_n)
            ext_cnt_ff <= 8'h00;
        else if (ext_cnt_ff != RST_CYC[7:0])
            ext_cnt_ff <= ext_cnt_ff + 8'h01;
    end
    assign srst = !rst_n_i || (ext_cnt_ff == RST_CYC[7:0]);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            iface_mode_o <= IF_RS485;
        else if (iface_select_sw_a_i)
            iface_mode_o <= IF_BAD;
        else if (!iface_select_sw_b_i)
            iface_mode_o <= IF_RS485;
        else
            iface_mode_o <= iface_select_sw_c_i ? IF_RS232 : IF_CMOS;
    end

    // Byte pacing: parallel link runs one byte per clock
    always_comb
    begin
        if (par_mode_i)
            period = 18'h00000;
        else if (st_ff == ST_ATR)
            period = 18'(ATR_BYTE_CYC - 1);
        else
            period = 18'(ATR_BYTE_CYC / bpf_rate_mul(rate_sel_i) - 1);
    end

    always_comb
    begin
        tx_byte = 8'h00;
        if (st_ff == ST_ATR)
        begin
            if (idx_ff < 9'd11)
                tx_byte = ATR_FIX[87 - 8*idx_ff -: 8];
            else if (idx_ff == 9'd11)
                tx_byte = FW_VER_HI;
            else if (idx_ff == 9'd12)
                tx_byte = FW_VER_LO;
            else if (idx_ff == 9'd13)
                tx_byte = `BPF_ATR_NAD;
            else
                tx_byte = ATR_TCK;
        end
        else
        begin
            case (idx_ff)
                9'd0: tx_byte = rep_nad_ff;
                9'd1: tx_byte = rep_pcb_ff;
                9'd2: tx_byte = 8'h00;
                9'd3: tx_byte = rep_chk_ff[7:0];
                default: tx_byte = rep_chk_ff[15:8];
            endcase
        end
    end

    assign tx_go   = (st_ff != ST_RX) && (pace_ff == 18'h00000);
    assign tx_last = (st_ff == ST_ATR) ? (idx_ff == `BPF_ATR_LEN - 9'd1) : (idx_ff == 9'd4);
    // Bytes arriving while the reader talks are dropped
    assign rx_b    = lk.h2r_vld && (st_ff == ST_RX);
    assign inf_end = `BPF_HDR_BYTES + {1'b0, rlen_ff};
    assign rx_last = rx_b && (idx_ff == inf_end + 9'd1);

    always_ff @(posedge clk_i)
    begin
        if (srst)
        begin
            st_ff      <= ST_ATR;
            idx_ff     <= 9'h000;
            pace_ff    <= 18'h00000;
            lk.r2h_vld <= 1'b0;
            lk.r2h_dat <= 8'h00;
            atr_done_o <= 1'b0;
        end
        else
        begin
            lk.r2h_vld <= tx_go;
            if (tx_go)
            begin
                lk.r2h_dat <= tx_byte;
                pace_ff    <= period;
                idx_ff     <= tx_last ? 9'h000 : idx_ff + 9'd1;
                if (tx_last)
                begin
                    st_ff      <= ST_RX;
                    atr_done_o <= 1'b1;
                end
            end
            else if (st_ff != ST_RX)
                pace_ff <= pace_ff - 18'h00001;
            else if (rx_last)
            begin
                st_ff   <= ST_TX;
                idx_ff  <= 9'h000;
                pace_ff <= period;
            end
            else if (rx_b)
                idx_ff <= idx_ff + 9'd1;
        end
    end

    // Running check over address through last info byte
    always_ff @(posedge clk_i)
    begin
        if (srst || rx_last)
        begin
            crc_ff <= `BPF_CRC_INIT;
            lrc_ff <= 8'h00;
        end
        else if (rx_b && idx_ff < inf_end)
        begin
            crc_ff <= bpf_crc_upd(crc_ff, lk.h2r_dat);
            lrc_ff <= lrc_ff ^ lk.h2r_dat;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst)
        begin
            rnad_ff <= 8'h00;
            rpcb_ff <= 8'h00;
            rlen_ff <= 8'h00;
            e1_ff   <= 8'h00;
        end
        else if (rx_b)
        begin
            case (idx_ff)
                9'd0: rnad_ff <= lk.h2r_dat;
                9'd1: rpcb_ff <= lk.h2r_dat;
                9'd2: rlen_ff <= lk.h2r_dat;
                default: e1_ff <= lk.h2r_dat;
            endcase
        end
    end

    // Reply decision on the closing check byte
    always_comb
    begin
        got    = {lk.h2r_dat, e1_ff};
        chk_ok = lrc_mode_i ? (got == {8'h00, lrc_ff}) : (got == ~crc_ff);
        nxt_ns = ns_ff;
        mgmt   = 1'b0;
        rp     = {`BPF_R_TAG, ns_ff, `BPF_ERR_OTHER};
        if (!chk_ok)
            rp = {`BPF_R_TAG, ns_ff, `BPF_ERR_CHK};
        else if (rlen_ff > `BPF_INF_MAX)
            rp = {`BPF_R_TAG, ns_ff, `BPF_ERR_OTHER};
        else if (!rpcb_ff[7])
        begin
            if (rpcb_ff[4:0] == 5'h00)
            begin
                nxt_ns = ns_ff ^ (rpcb_ff[6] == ns_ff);
                rp     = {`BPF_R_TAG, nxt_ns, `BPF_ERR_NONE};
            end
        end
        else if (!rpcb_ff[6])
        begin
            if (!rpcb_ff[5] && rlen_ff == 8'h00)
                rp = {`BPF_R_TAG, ns_ff, `BPF_ERR_NONE};
        end
        else
        begin
            rp = rpcb_ff | `BPF_S_RESP;
            if (rpcb_ff == `BPF_S_RESYNC)
                nxt_ns = 1'b0;
            mgmt = (rpcb_ff != `BPF_S_RESYNC) && (rpcb_ff != `BPF_S_ABORT)
                && (rpcb_ff != `BPF_S_WTX);
        end
        rnad_nxt = {1'b0, rnad_ff[2:0], `BPF_READER_NODE};
        rchk_nxt = ~bpf_crc_upd(bpf_crc_upd(bpf_crc_upd(`BPF_CRC_INIT, rnad_nxt), rp), 8'h00);
        if (lrc_mode_i)
            rchk_nxt = {8'h00, rnad_nxt ^ rp};
    end

    always_ff @(posedge clk_i)
    begin
        if (srst)
        begin
            ns_ff      <= 1'b0;
            rep_nad_ff <= 8'h00;
            rep_pcb_ff <= 8'h00;
            rep_chk_ff <= 16'h0000;
            blk_end_o  <= 1'b0;
            blk_ok_o   <= 1'b0;
            mgmt_o     <= 1'b0;
            mgmt_pcb_o <= 8'h00;
        end
        else
        begin
            blk_end_o <= rx_last;
            mgmt_o    <= rx_last && chk_ok && mgmt;
            if (rx_last)
            begin
                ns_ff      <= chk_ok ? nxt_ns : ns_ff;
                blk_ok_o   <= chk_ok;
                rep_nad_ff <= rnad_nxt;
                rep_pcb_ff <= rp;
                rep_chk_ff <= rchk_nxt;
                mgmt_pcb_o <= rpcb_ff;
            end
        end
    end

    // Info bytes stream out as they arrive; blk_ok_o at the end qualifies them
    always_ff @(posedge clk_i)
    begin
        if (srst)
        begin
            inf_vld_o <= 1'b0;
            inf_dat_o <= 8'h00;
        end
        else
        begin
            inf_vld_o <= rx_b && idx_ff >= `BPF_HDR_BYTES && idx_ff < inf_end;
            if (rx_b)
                inf_dat_o <= lk.h2r_dat;
        end
    end
endmodule : bpf_reader
`default_nettype wire

// ---- core/bpf_host.sv ----
// Host end: AHB-Lite command registers, block sender and reply parser
`timescale 1ns/1ps
`default_nettype none
module bpf_host
    import bpf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic [31:0]      hrdata_o,
    output logic             hresp_o,
    // Link
    bpf_if.host              lk
);
    localparam int RST_CYC = `BPF_EXT_RST_CYC;

    logic [7:0]  txb [0:253];
    logic        ap_wr_ff;
    logic [7:0]  ap_adr_ff;
    logic        we;
    logic        lrc_ff;
    logic [15:0] gap_ff;
    logic [23:0] hdr_ff;
    logic [7:0]  twp_ff;
    logic        busy_ff;
    logic        expect_ff;
    logic [8:0]  tidx_ff;
    logic [15:0] gcnt_ff;
    logic [15:0] tcrc_ff;
    logic [7:0]  tlrc_ff;
    logic [7:0]  tlen;
    logic [8:0]  tend;
    logic [7:0]  tx_byte;
    logic        start;
    logic [7:0]  rcnt_ff;
    logic [8:0]  ridx_ff;
    logic [7:0]  rnad_ff;
    logic [7:0]  rpcb_ff;
    logic [7:0]  rlen_ff;
    logic [7:0]  re1_ff;
    logic [15:0] rcrc_ff;
    logic [7:0]  rlrc_ff;
    logic        rx_b;
    logic        rx_last;
    logic [8:0]  rend;
    logic        rx_done_ff;
    logic        rx_ok_ff;
    logic [4:0]  atr_cnt_ff;

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign we          = ap_wr_ff;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ap_wr_ff  <= 1'b0;
            ap_adr_ff <= 8'h00;
            hrdata_o  <= 32'h00000000;
        end
        else
        begin
            ap_wr_ff <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
            if (hsel_i && htrans_i[1] && hready_i)
            begin
                ap_adr_ff <= haddr_i[7:0];
                case (haddr_i[7:0])
                    `BPF_REG_CTRL: hrdata_o <= {30'h00000000, lrc_ff, 1'b0};
                    `BPF_REG_HDR: hrdata_o <= {8'h00, hdr_ff};
                    `BPF_REG_STATUS: hrdata_o <= {rnad_ff, rlen_ff, rpcb_ff, atr_cnt_ff,
                        rx_ok_ff, rx_done_ff, busy_ff || expect_ff};
                    `BPF_REG_GAP: hrdata_o <= {16'h0000, gap_ff};
                    default: hrdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            lrc_ff <= 1'b0;
            gap_ff <= 16'h0000;
            hdr_ff <= 24'h000000;
        end
        else if (we && ap_adr_ff == `BPF_REG_CTRL)
            lrc_ff <= hwdata_i[1];
        else if (we && ap_adr_ff == `BPF_REG_GAP)
            gap_ff <= hwdata_i[15:0];
        else if (we && ap_adr_ff == `BPF_REG_HDR)
            hdr_ff <= hwdata_i[23:0];
    end

    // External reset pulse, stretched to the minimum width
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            rcnt_ff <= 8'h00;
        else if (we && ap_adr_ff == `BPF_REG_CTRL && hwdata_i[2])
            rcnt_ff <= RST_CYC[7:0];
        else if (rcnt_ff != 8'h00)
            rcnt_ff <= rcnt_ff - 8'h01;
    end
    assign lk.ext_rst_n = (rcnt_ff == 8'h00);

    // Half duplex: a start written before the previous reply is in is ignored, not held
    assign start = we && ap_adr_ff == `BPF_REG_CTRL && hwdata_i[0] && !busy_ff && !expect_ff;
    assign tlen  = (hdr_ff[23:16] > `BPF_INF_MAX) ? `BPF_INF_MAX : hdr_ff[23:16];
    assign tend  = `BPF_HDR_BYTES + {1'b0, tlen};

    always_ff @(posedge clk_i)
    begin
        if (we && ap_adr_ff == `BPF_REG_TXDATA && !busy_ff && twp_ff < `BPF_INF_MAX)
            txb[twp_ff] <= hwdata_i[7:0];
    end

    always_comb
    begin
        if (tidx_ff == 9'd0)
            tx_byte = hdr_ff[7:0];
        else if (tidx_ff == 9'd1)
            tx_byte = hdr_ff[15:8];
        else if (tidx_ff == 9'd2)
            tx_byte = tlen;
        else if (tidx_ff < tend)
            tx_byte = txb[8'(tidx_ff - `BPF_HDR_BYTES)];
        else if (tidx_ff == tend)
            tx_byte = lrc_ff ? tlrc_ff : ~tcrc_ff[7:0];
        else
            tx_byte = lrc_ff ? 8'h00 : ~tcrc_ff[15:8];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            busy_ff    <= 1'b0;
            expect_ff  <= 1'b0;
            tidx_ff    <= 9'h000;
            gcnt_ff    <= 16'h0000;
            twp_ff     <= 8'h00;
            tcrc_ff    <= `BPF_CRC_INIT;
            tlrc_ff    <= 8'h00;
            lk.h2r_vld <= 1'b0;
            lk.h2r_dat <= 8'h00;
        end
        else
        begin
            lk.h2r_vld <= busy_ff && gcnt_ff == 16'h0000;
            if (we && ap_adr_ff == `BPF_REG_TXDATA && !busy_ff && twp_ff < `BPF_INF_MAX)
                twp_ff <= twp_ff + 8'h01;
            if (rx_last)
                expect_ff <= 1'b0;
            if (start)
            begin
                busy_ff <= 1'b1;
                tidx_ff <= 9'h000;
                gcnt_ff <= 16'h0000;
                tcrc_ff <= `BPF_CRC_INIT;
                tlrc_ff <= 8'h00;
            end
            else if (busy_ff && gcnt_ff == 16'h0000)
            begin
                lk.h2r_dat <= tx_byte;
                gcnt_ff    <= gap_ff;
                tidx_ff    <= tidx_ff + 9'd1;
                if (tidx_ff < tend)
                begin
                    tcrc_ff <= bpf_crc_upd(tcrc_ff, tx_byte);
                    tlrc_ff <= tlrc_ff ^ tx_byte;
                end
                if (tidx_ff == tend + 9'd1)
                begin
                    busy_ff   <= 1'b0;
                    expect_ff <= 1'b1;
                    twp_ff    <= 8'h00;
                end
            end
            else if (busy_ff)
                gcnt_ff <= gcnt_ff - 16'h0001;
        end
    end

    assign rx_b    = lk.r2h_vld && expect_ff;
    assign rend    = `BPF_HDR_BYTES + {1'b0, rlen_ff};
    assign rx_last = rx_b && ridx_ff == rend + 9'd1;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ridx_ff    <= 9'h000;
            rnad_ff    <= 8'h00;
            rpcb_ff    <= 8'h00;
            rlen_ff    <= 8'h00;
            re1_ff     <= 8'h00;
            rcrc_ff    <= `BPF_CRC_INIT;
            rlrc_ff    <= 8'h00;
            rx_done_ff <= 1'b0;
            rx_ok_ff   <= 1'b0;
            atr_cnt_ff <= 5'h00;
        end
        else
        begin
            // A reply landing on the clear cycle keeps its flag
            if (rx_last)
                rx_done_ff <= 1'b1;
            else if (we && ap_adr_ff == `BPF_REG_STATUS && hwdata_i[1])
                rx_done_ff <= 1'b0;
            if (!lk.ext_rst_n)
                atr_cnt_ff <= 5'h00;
            else if (lk.r2h_vld && !expect_ff && atr_cnt_ff != 5'h1F)
                atr_cnt_ff <= atr_cnt_ff + 5'h01;
            if (rx_b)
            begin
                ridx_ff <= rx_last ? 9'h000 : ridx_ff + 9'd1;
                case (ridx_ff)
                    9'd0: rnad_ff <= lk.r2h_dat;
                    9'd1: rpcb_ff <= lk.r2h_dat;
                    9'd2: rlen_ff <= lk.r2h_dat;
                    default: re1_ff <= lk.r2h_dat;
                endcase
                if (ridx_ff < rend)
                begin
                    rcrc_ff <= bpf_crc_upd(rcrc_ff, lk.r2h_dat);
                    rlrc_ff <= rlrc_ff ^ lk.r2h_dat;
                end
                if (rx_last)
                begin
                    rcrc_ff  <= `BPF_CRC_INIT;
                    rlrc_ff  <= 8'h00;
                    rx_ok_ff <= lrc_ff ? ({lk.r2h_dat, re1_ff} == {8'h00, rlrc_ff})
                        : ({lk.r2h_dat, re1_ff} == ~rcrc_ff);
                end
            end
        end
    end
endmodule : bpf_host
`default_nettype wire

// ---- sim/bpf_link_sva.sv ----
// Link checker for the host and reader pair
`timescale 1ns/1ps
`default_nettype none
module bpf_link_sva #(
    parameter int ATR_BYTE_CYC = 48
)(
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // Link
    input wire logic       h2r_vld,
    input wire logic       r2h_vld,
    input wire logic [7:0] r2h_dat,
    input wire logic       ext_rst_n,
    // Link mode
    input wire logic       par_mode_i
);
    logic [7:0]  low_ff;
    logic [15:0] gap_ff;
    logic [5:0]  idx_ff;
    logic [7:0]  xor_ff;
    logic        atr_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || ext_rst_n)
            low_ff <= 8'h00;
        else if (low_ff != 8'hFF)
            low_ff <= low_ff + 8'h01;
    end
    // Either reset restarts tracking; an external pulse restarts the start-up string only if held 125 cycles
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !ext_rst_n)
        begin
            atr_ff <= 1'b1;
            idx_ff <= 6'h00;
            xor_ff <= 8'h00;
            gap_ff <= 16'h0000;
        end
        else
        begin
            gap_ff <= r2h_vld ? 16'h0001 : gap_ff + 16'h0001;
            atr_ff <= atr_ff && !h2r_vld;
            if (r2h_vld && idx_ff != 6'h3F)
                idx_ff <= idx_ff + 6'h01;
            if (r2h_vld && idx_ff != 6'h00)
                xor_ff <= xor_ff ^ r2h_dat;
        end
    end
    sequence s_ts;
        r2h_vld && r2h_dat == 8'h3B;
    endsequence
    a_atr_first: assert property ($rose(rst_n_i) |-> ##[1:4] s_ts)
        else $error("start-up string does not open with 3B");
    a_atr_restart: assert property ($rose(ext_rst_n) && low_ff >= 8'h7D |-> ##[1:4] s_ts)
        else $error("no start-up string after external reset");
    a_atr_pace: assert property (atr_ff && r2h_vld && idx_ff inside {[1:14]}
        |-> gap_ff == (par_mode_i ? 1 : ATR_BYTE_CYC)) else $error("start-up byte spacing wrong");
    a_atr_max: assert property (atr_ff && r2h_vld |-> idx_ff < 6'h21)
        else $error("start-up string too long");
    a_atr_check: assert property (atr_ff && r2h_vld && idx_ff == 6'h0E
        |-> (xor_ff ^ r2h_dat) == 8'h00) else $error("start-up check byte wrong");
    a_half_duplex: assert property (!(h2r_vld && r2h_vld))
        else $error("both ends send at once");
    a_ext_hold: assert property ($fell(ext_rst_n) |-> !ext_rst_n [*8])
        else $error("external reset pulse cut short");
    a_ext_len: assert property ($rose(ext_rst_n) |-> low_ff >= 8'h7D)
        else $error("external reset shorter than 125 cycles");
    a_rst_quiet: assert property ($rose(ext_rst_n) && low_ff >= 8'h7D
        |=> !r2h_vld ##1 r2h_vld) else $error("reader restart timing wrong");
endmodule : bpf_link_sva
`default_nettype wire

// ---- sim/tb_top.sv ----
// Testbench: host and reader joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "bpf_cfg.svh"
module tb_top;
    localparam logic [14:0] SW_T = 15'h44C8;
    localparam logic [9:0]  MD_T = 10'h390;
    localparam logic [31:0] S_T  = 32'hC5C3C2C0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, st;
    logic [1:0]  htrans = 2'h0, mode;
    logic [2:0]  sw = 3'h0;
    logic [7:0]  inf_dat, mgmt_pcb, x, protocol_control_byte, rx_q[$], inf_q[$];
    logic        clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hrdy, lrc = 1'b0;
    logic        atr_done, inf_vld, blk_ok, mgmt, mgmt_seen = 1'b0, par = 1'b0, hresp, blk_end;
    int          err_count = 0, n_compared = 0, tx_n = 0, blk_n = 0;
    bpf_if lk ();
    bpf_reader #(.ATR_BYTE_CYC(48)) bpf_reader_i (.clk_i(clk), .rst_n_i(rst_n), .lk(lk),
        .par_mode_i(par), .rate_sel_i(3'h5), .lrc_mode_i(lrc), .iface_select_sw_a_i(sw[2]),
        .iface_select_sw_b_i(sw[1]), .iface_select_sw_c_i(sw[0]), .iface_mode_o(mode),
        .atr_done_o(atr_done), .inf_vld_o(inf_vld), .inf_dat_o(inf_dat), .blk_end_o(blk_end),
        .blk_ok_o(blk_ok), .mgmt_o(mgmt), .mgmt_pcb_o(mgmt_pcb));
    bpf_host bpf_host_i (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hreadyout_o(hrdy), .hrdata_o(hrdata), .hresp_o(hresp), .lk(lk));
    bpf_link_sva #(.ATR_BYTE_CYC(48)) bpf_link_sva_i (.clk_i(clk), .rst_n_i(rst_n),
        .h2r_vld(lk.h2r_vld), .r2h_vld(lk.r2h_vld), .r2h_dat(lk.r2h_dat),
        .ext_rst_n(lk.ext_rst_n), .par_mode_i(par));
    initial
    begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (lk.r2h_vld === 1'b1)
            rx_q.push_back(lk.r2h_dat);
        if (lk.h2r_vld === 1'b1)
            tx_n++;
        if (inf_vld === 1'b1)
            inf_q.push_back(inf_dat);
        if (mgmt === 1'b1)
            mgmt_seen = 1'b1;
        if (blk_end === 1'b1)
            blk_n++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1);
        st = hrdata;
    endtask : bus
    // Header is {length, control, address}; info bytes run A0, A1, ...
    task automatic send(input logic [23:0] hdr, input logic hl, input int nb);
        bus(1'b1, `BPF_REG_STATUS, 32'h2);
        bus(1'b1, `BPF_REG_HDR, {8'h00, hdr});
        for (int i = 0; i < nb; i++)
            bus(1'b1, `BPF_REG_TXDATA, 32'hA0 + i);
        bus(1'b1, `BPF_REG_CTRL, {30'h0, hl, 1'b1});
        st = '0;
        for (int i = 0; i < 300 && st[1] !== 1'b1; i++)
            bus(1'b0, `BPF_REG_STATUS, 32'h0);
    endtask : send
    task automatic atr_chk();
        for (int i = 0; i < 2000 && atr_done !== 1'b1; i++)
            @(posedge clk);
        // Let the last captured byte land before counting
        repeat (2) @(posedge clk);
        x = 8'h00;
        foreach (rx_q[i])
            x ^= (i > 0) ? rx_q[i] : 8'h00;
        chk(rx_q.size(), 15);
        chk(rx_q[0], 8'h3B);
        chk(x, 8'h00);
        bus(1'b0, `BPF_REG_STATUS, 32'h0);
        chk(st[7:3], 5'h0F);
    endtask : atr_chk
    task automatic stop_test();
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        atr_chk();
        bus(1'b0, 8'h20, 32'h0);
        chk(st, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            sw <= SW_T[i*3 +: 3];
            repeat (3) @(posedge clk);
            chk(mode, MD_T[i*2 +: 2]);
        end
        send(24'h020012, 1'b0, 2);
        chk({inf_q[0], inf_q[1]}, 16'hA0A1);
        chk(st[31:8], 24'h210090);
        chk({blk_ok, st[2], 8'(tx_n), 8'(rx_q.size())}, 18'h30714);
        send(24'h004012, 1'b1, 0);
        chk({blk_ok, st[15:8]}, 9'h091);
        lrc <= 1'b1;
        send(24'h006012, 1'b1, 0);
        chk({blk_ok, st[2], st[15:8]}, 10'h380);
        lrc <= 1'b0;
        // Spaced host bytes for the supervisory blocks
        bus(1'b1, `BPF_REG_GAP, 32'h2);
        bus(1'b0, `BPF_REG_GAP, 32'h0);
        chk(st, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            protocol_control_byte = S_T[i*8 +: 8];
            mgmt_seen = 1'b0;
            send({8'h00, protocol_control_byte, 8'h12}, 1'b0, 0);
            chk({mgmt_seen, st[15:8]}, {protocol_control_byte == 8'hC5, protocol_control_byte | 8'h20});
        end
        chk(mgmt_pcb, 8'hC5);
        send(24'h018012, 1'b0, 1);
        chk(st[15:8], 8'h82);
        chk({hresp, 8'(blk_n)}, 9'h008);
        par <= 1'b1;
        rx_q.delete();
        bus(1'b1, `BPF_REG_CTRL, 32'h4);
        // The line is still high when the write lands; wait for the reader's reset
        for (int i = 0; i < 400 && atr_done !== 1'b0; i++)
            @(posedge clk);
        atr_chk();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
